// File: lsch_handler.sv
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module lsch_handler #(
   parameter int REPORT_CYCLES = lsch_pkg::REPORT_CYC,
   parameter int DEVICES = 32,
   parameter logic [7:0] FAM_A = 8'hA5, // arbitrary value, first supported sensor family
   parameter logic [7:0] FAM_B = 8'h5A // arbitrary value, second supported sensor family
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // command packet in
   input wire logic pktValid,
   input wire lsch_pkg::lsch_pkt_t pktIn,
   // reply packet out
   output logic rspValid,
   output lsch_pkg::lsch_pkt_t rspOut,
   // boot state store and display settings restore; bootGlyph is never read
   input wire logic bootValid,
   input wire lsch_pkg::lsch_disp_t bootDisp,
   input wire logic [63:0] bootGlyph [8],
   output logic storeReq,
   // display controller memory port
   output logic memRdReq,
   output logic [7:0] memRdAddr,
   input wire logic memRdDone,
   input wire logic [63:0] memRdData,
   // glyph memory write
   output logic glyphWr,
   output logic [2:0] glyphSlot,
   output logic [63:0] glyphRows,
   // sensor bus enumeration
   output logic enumReq,
   input wire logic idValid,
   input wire logic [4:0] idIndex,
   input wire logic [63:0] idData,
   input wire logic enumDone,
   // temperature reporting and display settings
   output logic [31:0] reportMask,
   output logic reportTick,
   output lsch_pkg::lsch_disp_t dispOut
);
   import lsch_pkg::*;

   typedef enum logic [1:0] {IDLE, MEMWAIT, ENUM} lsch_st_t;
   typedef struct packed {
      lsch_st_t st;
      logic rspValid;
      lsch_pkt_t rsp;
      logic storeReq;
      logic memRdReq;
      logic [7:0] memAddr;
      logic glyphWr;
      logic [2:0] glyphSlot;
      logic [63:0] glyphRows;
      logic enumReq;
      logic booted;
      logic [31:0] found;
      logic [31:0] mask;
      logic [31:0] tick;
      logic reportTick;
      lsch_disp_t disp;
   } lsch_state_t;

   lsch_state_t s_r, s_nxt;
   logic [63:0] idMem [DEVICES];

   // payload byte n of a packet
   function automatic logic [7:0] pb(input lsch_pkt_t p, input int n);
      pb = p.data[n*8 +: 8];
   endfunction : pb

   // acknowledge with empty payload
   function automatic lsch_pkt_t ack(input logic [7:0] c);
      ack = '0;
      ack.cmd = c | RSP_FLAG;
   endfunction : ack

   // identity memory written during enumeration
   always_ff @(posedge clk) begin
      if (idValid) begin
         idMem[idIndex] <= idData;
      end
   end

   // next state
   always_comb begin
      logic ok;
      logic [63:0] rows;
      ok = 1'b0;
      rows = '0;
      s_nxt = s_r;
      s_nxt.rspValid = 1'b0;
      s_nxt.storeReq = 1'b0;
      s_nxt.memRdReq = 1'b0;
      s_nxt.glyphWr = 1'b0;
      s_nxt.enumReq = 1'b0;
      s_nxt.reportTick = 1'b0;
      // one second reporting tick
      if (s_r.tick >= 32'(REPORT_CYCLES - 1)) begin
         s_nxt.tick = '0;
         s_nxt.reportTick = |(s_r.mask & s_r.found);
      end else begin
         s_nxt.tick = s_r.tick + 32'h00000001;
      end
      // restore boot settings once
      if (!s_r.booted && bootValid) begin
         s_nxt.booted = 1'b1;
         s_nxt.disp = bootDisp;
         s_nxt.enumReq = 1'b1;
         s_nxt.st = ENUM;
      end
      // only supported temperature families may report
      if (idValid && (idData[7:0] == FAM_A || idData[7:0] == FAM_B)) begin
         s_nxt.found[idIndex] = 1'b1;
      end
      unique case (s_r.st)
         IDLE: begin
            if (pktValid) begin
               s_nxt.rsp = ack(pktIn.cmd);
               unique case (pktIn.cmd)
                  CMD_STORE: begin
                     ok = pktIn.len == 5'd0;
                     s_nxt.storeReq = ok;
                  end
                  CMD_GLYPH: begin
                     ok = pktIn.len == 5'd9 && pb(pktIn, 0) <= 8'h07;
                     for (int i = 0; i < 8; i++) begin
                        if (pb(pktIn, i + 1) > GLYPH_MAX) begin
                           ok = 1'b0;
                        end
                        rows[63 - i*8 -: 8] = pb(pktIn, i + 1);
                     end
                     if (ok) begin
                        s_nxt.glyphWr = 1'b1;
                        s_nxt.glyphSlot = pktIn.data[2:0];
                        s_nxt.glyphRows = rows;
                     end
                  end
                  CMD_MEMRD: begin
                     ok = pktIn.len == 5'd1;
                     if (ok) begin
                        s_nxt.memRdReq = 1'b1;
                        s_nxt.memAddr = pb(pktIn, 0);
                        s_nxt.st = MEMWAIT;
                     end
                  end
                  CMD_CURPOS: begin
                     ok = pktIn.len == 5'd2 && pb(pktIn, 0) <= COL_MAX
                          && pb(pktIn, 1) <= ROW_MAX;
                     if (ok) begin
                        s_nxt.disp.curCol = pktIn.data[3:0];
                        s_nxt.disp.curRow = pktIn.data[8];
                     end
                  end
                  CMD_CURSTY: begin
                     ok = pktIn.len == 5'd1 && pb(pktIn, 0) <= STYLE_MAX;
                     if (ok) begin
                        s_nxt.disp.curStyle = pktIn.data[1:0];
                     end
                  end
                  CMD_CONTRAST: begin
                     if (pktIn.len == 5'd1) begin
                        ok = pb(pktIn, 0) <= LEGACY_MAX;
                        if (ok) begin
                           s_nxt.disp.contrast = pb(pktIn, 0);
                        end
                     end else if (pktIn.len == 5'd2) begin
                        ok = 1'b1;
                        s_nxt.disp.contrast = pb(pktIn, 1);
                     end
                  end
                  CMD_BACKLIGHT: begin
                     if (pktIn.len == 5'd1) begin
                        ok = 1'b1;
                        s_nxt.disp.lcdLight = pb(pktIn, 0);
                        s_nxt.disp.keyLight = pb(pktIn, 0);
                     end else if (pktIn.len == 5'd2) begin
                        ok = 1'b1;
                        s_nxt.disp.lcdLight = pb(pktIn, 0);
                        s_nxt.disp.keyLight = pb(pktIn, 1);
                     end
                  end
                  CMD_IDENT: begin
                     ok = pktIn.len == 5'd1 && pb(pktIn, 0) <= DEV_MAX;
                     if (ok) begin
                        s_nxt.rsp.len = 5'd9;
                        s_nxt.rsp.data[7:0] = pb(pktIn, 0);
                        // family code leads the identity
                        for (int i = 0; i < 8; i++) begin
                           s_nxt.rsp.data[(i+1)*8 +: 8] =
                              idMem[pktIn.data[4:0]][i*8 +: 8];
                        end
                     end
                  end
                  CMD_TEMPREP: begin
                     ok = pktIn.len == 5'd4;
                     if (ok) begin
                        s_nxt.mask = pktIn.data[31:0];
                     end
                  end
                  default: ok = 1'b0;
               endcase
               // rejected packets restore everything
               if (!ok) begin
                  s_nxt.disp = s_r.disp;
                  s_nxt.mask = s_r.mask;
                  s_nxt.rsp = '0;
                  s_nxt.rsp.cmd = pktIn.cmd | ERR_FLAG;
               end
               s_nxt.rspValid = pktIn.cmd != CMD_MEMRD || !ok;
            end
         end
         MEMWAIT: begin
            if (memRdDone) begin
               s_nxt.rsp.len = 5'd9;
               s_nxt.rsp.data[7:0] = s_r.memAddr;
               s_nxt.rsp.data[71:8] = memRdData;
               s_nxt.rspValid = 1'b1;
               s_nxt.st = IDLE;
            end
         end
         ENUM: begin
            if (enumDone) begin
               s_nxt.st = IDLE;
            end
         end
         default: s_nxt.st = IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_r <= '0;
         s_r.disp.contrast <= RST_CONTRAST;
         s_r.disp.lcdLight <= RST_LIGHT;
         s_r.disp.keyLight <= RST_LIGHT;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs
   assign rspValid = s_r.rspValid;
   assign rspOut = s_r.rsp;
   assign storeReq = s_r.storeReq;
   assign memRdReq = s_r.memRdReq;
   assign memRdAddr = s_r.memAddr;
   assign glyphWr = s_r.glyphWr;
   assign glyphSlot = s_r.glyphSlot;
   assign glyphRows = s_r.glyphRows;
   assign enumReq = s_r.enumReq;
   assign reportMask = s_r.mask & s_r.found;
   assign reportTick = s_r.reportTick;
   assign dispOut = s_r.disp;
endmodule : lsch_handler

// File: lsch_pkg.sv
// Behaviour
// - glyph command: nine bytes, slot 0-7
// - glyph rows 0-63, top row first
// - reply type is command OR 0x40
// - memory read echoes address plus eight bytes
// - cursor: column 0-15, row 0-1
// - cursor style picks one of four
// - one-byte contrast accepts 0-200
// - two-byte contrast uses second byte
// - one-byte backlight sets both lights
// - two-byte backlight sets each light
// - settings saved and restored at boot
// - enumerate sensor bus at power-up
// - identity query: index 0-31, nine-byte reply
// - first identity byte is family code
// - supported sensor families report temperature
// - reporting command takes 32-bit mask
// - mask bit n enables sensor n
// - enabled sensors report every second
package lsch_pkg;
   localparam logic [7:0] CMD_STORE = 8'h04;
   localparam logic [7:0] CMD_GLYPH = 8'h09;
   localparam logic [7:0] CMD_MEMRD = 8'h0A;
   localparam logic [7:0] CMD_CURPOS = 8'h0B;
   localparam logic [7:0] CMD_CURSTY = 8'h0C;
   localparam logic [7:0] CMD_CONTRAST = 8'h0D;
   localparam logic [7:0] CMD_BACKLIGHT = 8'h0E;
   localparam logic [7:0] CMD_IDENT = 8'h12;
   localparam logic [7:0] CMD_TEMPREP = 8'h13;
   localparam logic [7:0] RSP_FLAG = 8'h40;
   localparam logic [7:0] ERR_FLAG = 8'hC0;
   localparam logic [7:0] GLYPH_MAX = 8'h3F;
   localparam logic [7:0] COL_MAX = 8'h0F;
   localparam logic [7:0] ROW_MAX = 8'h01;
   localparam logic [7:0] STYLE_MAX = 8'h03;
   localparam logic [7:0] LEGACY_MAX = 8'hC8;
   localparam logic [7:0] DEV_MAX = 8'h1F;
   localparam logic [7:0] RST_CONTRAST = 8'h10;
   localparam logic [7:0] RST_LIGHT = 8'h64;
   localparam int PERIOD_NS = 8;
   localparam longint REPORT_NS = 64'd1000000000;
   localparam int REPORT_CYC = int'(REPORT_NS / PERIOD_NS);
   localparam int PAYLOAD_MAX = 16;
   localparam int ENUM_WAIT_CYC = 16;
   // one received command packet
   typedef struct packed {
      logic [7:0] cmd;
      logic [4:0] len;
      logic [PAYLOAD_MAX*8-1:0] data;
   } lsch_pkt_t;
   // display settings seen by the display driver
   typedef struct packed {
      logic [3:0] curCol;
      logic curRow;
      logic [1:0] curStyle;
      logic [7:0] contrast;
      logic [7:0] lcdLight;
      logic [7:0] keyLight;
   } lsch_disp_t;
endpackage : lsch_pkg

// File: lsch_handler_sva.sv
`timescale 1ns/10ps
module lsch_handler_chk (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // packets
   input wire logic pktValid,
   input wire lsch_pkg::lsch_pkt_t pktIn,
   input wire logic rspValid,
   input wire lsch_pkg::lsch_pkt_t rspOut,
   // side outputs and memory read return
   input wire logic storeReq,
   input wire logic memRdDone,
   input wire logic [63:0] memRdData,
   input wire logic glyphWr,
   input wire logic [2:0] glyphSlot,
   input wire logic [63:0] glyphRows,
   input wire logic [31:0] reportMask,
   input wire logic reportTick,
   input wire lsch_pkg::lsch_disp_t dispOut
);
   import lsch_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   // reply and side effects tied to their cause
   a_reply_type: assert property (
      rspValid && $past(pktValid) |-> rspOut.cmd[5:0] == $past(pktIn.cmd[5:0]) && rspOut.cmd[6])
      else $error("reply type does not match command");
   a_store_cause: assert property (
      storeReq |-> $past(pktValid) && $past(pktIn.cmd) == CMD_STORE)
      else $error("store request without store command");
   a_glyph_slot: assert property (
      glyphWr |-> $past(pktIn.cmd) == CMD_GLYPH && $past(pktIn.data[7:0]) <= 8'h07
         && glyphSlot == $past(pktIn.data[2:0]))
      else $error("glyph write with bad slot");
   a_glyph_rows: assert property (
      glyphWr |-> glyphRows[63:56] == $past(pktIn.data[15:8])
         && glyphRows[7:0] == $past(pktIn.data[71:64]))
      else $error("glyph rows out of order");
   a_memrd_echo: assert property (
      rspValid && rspOut.cmd == (CMD_MEMRD | RSP_FLAG) |-> $past(memRdDone)
         && rspOut.len == 5'd9 && rspOut.data[71:8] == $past(memRdData))
      else $error("memory read reply wrong");
   a_cursor_set: assert property (
      rspValid && rspOut.cmd == (CMD_CURPOS | RSP_FLAG) |-> dispOut.curCol == $past(pktIn.data[3:0])
         && dispOut.curRow == $past(pktIn.data[8]))
      else $error("cursor not placed");
   a_mask_cause: assert property (
      $changed(reportMask) |-> rspValid && rspOut.cmd == (CMD_TEMPREP | RSP_FLAG))
      else $error("mask changed without command");
   a_error_still: assert property (
      rspValid && rspOut.cmd[7:6] == 2'b11 |-> $stable(dispOut) && $stable(reportMask)
         && rspOut.len == 5'd0)
      else $error("rejected packet changed state");
   a_tick_masked: assert property (
      reportTick |-> reportMask != 32'h0)
      else $error("report tick with empty mask");
endmodule : lsch_handler_chk
bind lsch_handler lsch_handler_chk lsch_handler_chk_inst (.clk(clk), .reset_n(reset_n),
   .pktValid(pktValid), .pktIn(pktIn), .rspValid(rspValid), .rspOut(rspOut),
   .storeReq(storeReq), .memRdDone(memRdDone), .memRdData(memRdData), .glyphWr(glyphWr),
   .glyphSlot(glyphSlot), .glyphRows(glyphRows), .reportMask(reportMask),
   .reportTick(reportTick), .dispOut(dispOut));

// File: lsch_far_model.sv
`timescale 1ns/10ps
module lsch_far_model #(
   parameter int RD_WAIT = 3,
   parameter logic [7:0] FAM = 8'hA5 // arbitrary family code
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // display memory
   input wire logic memRdReq,
   input wire logic [7:0] memRdAddr,
   output logic memRdDone,
   output logic [63:0] memRdData,
   // sensor bus
   input wire logic enumReq,
   output logic idValid,
   output logic [4:0] idIndex,
   output logic [63:0] idData,
   output logic enumDone
);
   int rdCnt;
   int enCnt;
   logic [4:0] found [4] = '{5'h00, 5'h01, 5'h02, 5'h1F};
   // odd addresses answer slowly; idle data lines toggle
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdCnt <= -1;
         enCnt <= -1;
         {memRdDone, idValid, enumDone} <= 3'h0;
         {memRdData, idData, idIndex} <= '1;
      end else begin
         memRdDone <= (rdCnt == 0);
         memRdData <= (rdCnt == 0) ? {8{memRdAddr}} ^ 64'h0123456789ABCDEF : ~memRdData;
         rdCnt <= memRdReq ? RD_WAIT * memRdAddr[0] : (rdCnt >= 0 ? rdCnt - 1 : -1);
         // enumeration starts on each enumReq; four sensors answer, then enumDone
         idValid <= enCnt >= 0 && enCnt < 4;
         idIndex <= found[enCnt[1:0]];
         idData <= (enCnt >= 0 && enCnt < 4) ? {56'(enCnt), FAM} : ~idData;
         enumDone <= (enCnt == 4);
         enCnt <= enumReq ? 0 : (enCnt >= 0 && enCnt < 4 ? enCnt + 1 : -1);
      end
   end
endmodule : lsch_far_model

// File: test_lcd_sensor_command_handler.sv
`timescale 1ns/10ps
module test_lcd_sensor_command_handler;
   import lsch_pkg::*;
   localparam logic [7:0] FAM = 8'hA5;
   logic clk = 0;
   logic reset_n = 0;
   logic pktValid = 0;
   logic bootValid = 0;
   lsch_pkt_t pktIn = '0;
   lsch_pkt_t rspOut;
   lsch_disp_t dispOut;
   lsch_disp_t bootDisp = {4'h5, 1'b1, 2'h2, 8'h21, 8'h33, 8'h44};
   logic [63:0] bootGlyph [8] = '{default: 64'h0};
   logic rspValid, storeReq, memRdReq, memRdDone, glyphWr, enumReq, idValid, enumDone, reportTick;
   logic [7:0] memRdAddr;
   logic [63:0] memRdData, glyphRows, idData;
   logic [2:0] glyphSlot;
   logic [4:0] idIndex;
   logic [31:0] reportMask;
   logic [7:0] adrs [2] = '{8'h80, 8'h41};
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   always #4 clk = ~clk;
   lsch_handler #(.REPORT_CYCLES(100)) lsch_handler_inst (.clk(clk), .reset_n(reset_n),
      .pktValid(pktValid), .pktIn(pktIn), .rspValid(rspValid), .rspOut(rspOut),
      .bootValid(bootValid), .bootDisp(bootDisp), .bootGlyph(bootGlyph), .storeReq(storeReq),
      .memRdReq(memRdReq), .memRdAddr(memRdAddr), .memRdDone(memRdDone), .memRdData(memRdData),
      .glyphWr(glyphWr), .glyphSlot(glyphSlot), .glyphRows(glyphRows), .enumReq(enumReq),
      .idValid(idValid), .idIndex(idIndex), .idData(idData), .enumDone(enumDone),
      .reportMask(reportMask), .reportTick(reportTick), .dispOut(dispOut));
   lsch_far_model #(.FAM(FAM)) lsch_far_model_inst (.clk(clk), .reset_n(reset_n),
      .memRdReq(memRdReq), .memRdAddr(memRdAddr), .memRdDone(memRdDone), .memRdData(memRdData),
      .enumReq(enumReq), .idValid(idValid), .idIndex(idIndex), .idData(idData),
      .enumDone(enumDone));
   // verdict and end of run
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [71:0] got, input logic [71:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one packet, then wait for its reply
   task automatic run(input logic [7:0] c, input logic [4:0] n, input logic [127:0] d,
         input logic [7:0] exp);
      @(posedge clk);
      pktValid <= 1'b1;
      pktIn <= '{cmd: c, len: n, data: d};
      @(posedge clk);
      pktValid <= 1'b0;
      @(negedge clk);
      for (int k = 0; k < 20 && rspValid !== 1'b1; k++) @(negedge clk);
      chk(rspOut.cmd, exp);
   endtask : run
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      bootValid <= 1'b1;
      for (int k = 0; k < 30 && enumDone !== 1'b1; k++) @(negedge clk);
      chk(dispOut, bootDisp);
      repeat (2) @(negedge clk);
      run(CMD_CURPOS, 5'd2, 'h010F, CMD_CURPOS | RSP_FLAG);
      chk({dispOut.curCol, dispOut.curRow}, 5'h1F);
      run(CMD_CURPOS, 5'd2, 'h0010, CMD_CURPOS | ERR_FLAG);
      run(CMD_CURPOS, 5'd2, 'h0200, CMD_CURPOS | ERR_FLAG);
      chk({dispOut.curCol, dispOut.curRow}, 5'h1F);
      run(CMD_CURSTY, 5'd1, 'h03, CMD_CURSTY | RSP_FLAG);
      chk(dispOut.curStyle, 2'h3);
      run(CMD_CURSTY, 5'd1, 'h04, CMD_CURSTY | ERR_FLAG);
      run(CMD_CONTRAST, 5'd1, 'hC8, CMD_CONTRAST | RSP_FLAG);
      run(CMD_CONTRAST, 5'd1, 'hC9, CMD_CONTRAST | ERR_FLAG);
      chk(dispOut.contrast, 8'hC8);
      run(CMD_CONTRAST, 5'd2, 'h2AFF, CMD_CONTRAST | RSP_FLAG);
      chk(dispOut.contrast, 8'h2A);
      run(CMD_BACKLIGHT, 5'd1, 'h55, CMD_BACKLIGHT | RSP_FLAG);
      chk({dispOut.lcdLight, dispOut.keyLight}, 16'h5555);
      run(CMD_BACKLIGHT, 5'd2, 'h2211, CMD_BACKLIGHT | RSP_FLAG);
      chk({dispOut.lcdLight, dispOut.keyLight}, 16'h1122);
      run(CMD_GLYPH, 5'd9, 'h3F01020304050A2107, CMD_GLYPH | RSP_FLAG);
      chk({glyphSlot, glyphRows}, {3'h7, 64'h210A05040302013F});
      run(CMD_GLYPH, 5'd9, 'h3F01020304050A2108, CMD_GLYPH | ERR_FLAG);
      run(CMD_GLYPH, 5'd9, 'h3F01020304050A4003, CMD_GLYPH | ERR_FLAG);
      foreach (adrs[i]) begin
         run(CMD_MEMRD, 5'd1, 128'(adrs[i]), CMD_MEMRD | RSP_FLAG);
         chk(rspOut.data[71:0], {{8{adrs[i]}} ^ 64'h0123456789ABCDEF, adrs[i]});
      end
      run(CMD_IDENT, 5'd1, 'h02, CMD_IDENT | RSP_FLAG);
      chk({rspOut.len, rspOut.data[71:0]}, {5'd9, 56'h2, FAM, 8'h02});
      run(CMD_IDENT, 5'd1, 'h20, CMD_IDENT | ERR_FLAG);
      run(CMD_TEMPREP, 5'd4, 'h80000007, CMD_TEMPREP | RSP_FLAG);
      chk(reportMask, 32'h80000007);
      for (int k = 0; k < 120 && reportTick !== 1'b1; k++) @(negedge clk);
      chk(reportTick, 1'b1);
      run(CMD_TEMPREP, 5'd3, 'h0, CMD_TEMPREP | ERR_FLAG);
      chk(reportMask, 32'h80000007);
      run(CMD_STORE, 5'd0, 'h0, CMD_STORE | RSP_FLAG);
      chk(storeReq, 1'b1);
      run(CMD_TEMPREP, 5'd4, 'h0, CMD_TEMPREP | RSP_FLAG);
      chk(reportMask, 32'h0);
      wrap_up();
   end
endmodule : test_lcd_sensor_command_handler
